// File: verilog/pmw_consts.svh
/*
 Constants of the power-mode and wake controller: register word offsets,
 field positions, reset values and sequencing times.
 Assumes a 10 MHz system clock and word addressing on the register bus.
*/
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH

// Register word offsets
`define PMW_OFS_CTRL       4'h0
`define PMW_OFS_STATUS     4'h1
`define PMW_OFS_WAKE_EN    4'h2
`define PMW_OFS_DOMAIN     4'h3
`define PMW_OFS_OSC        4'h4

// Field positions
`define PMW_CTRL_MODE_LSB  0
`define PMW_CTRL_GO_BIT    3
`define PMW_CTRL_PFO_BIT   4
`define PMW_CTRL_BRO_BIT   5
`define PMW_CTRL_ICACHE_BIT 6
`define PMW_CTRL_NRO_LSB   8
`define PMW_CTRL_RET_LSB   12
`define PMW_STAT_BUSY_BIT  4
`define PMW_STAT_WOKE_BIT  8

// Reset values, the illegal nano select and RAM bank masks
`define PMW_NRO_RST        2'h0
`define PMW_NRO_ILLEGAL    2'h3
`define PMW_RET_RST        4'hf
`define PMW_WAKE_EN_RST    8'hff
`define PMW_COPROC_BANKS   4'hc
`define PMW_LP_RET_BANKS   4'h3

// Sequencing times and derived cycle counts
`define PMW_CLK_PERIOD_NS  100
`define PMW_OSC_SETTLE_NS  2000
`define PMW_DOM_SETTLE_NS  500
`define PMW_SYS_INIT_NS    10000
`define PMW_CYC(ns) (((ns) + `PMW_CLK_PERIOD_NS - 1) / `PMW_CLK_PERIOD_NS)
`define PMW_OSC_SETTLE_CYC `PMW_CYC(`PMW_OSC_SETTLE_NS)
`define PMW_DOM_SETTLE_CYC `PMW_CYC(`PMW_DOM_SETTLE_NS)
`define PMW_SYS_INIT_CYC   `PMW_CYC(`PMW_SYS_INIT_NS)

`endif

// File: verilog/pmw_pkg.sv
/*
 Types of the power-mode and wake controller: states, oscillator enables,
 wake sources and domain controls.
 Uses no constant from pmw_consts.svh; the state codes are given here.
*/
package pmw_pkg;

   typedef enum logic [3:0] {
      PMW_ACTIVE    = 4'h0,
      PMW_SLEEP     = 4'h1,
      PMW_LOWPWR    = 4'h2,
      PMW_MICRO     = 4'h3,
      PMW_STANDBY   = 4'h4,
      PMW_BACKUP    = 4'h5,
      PMW_PWRDOWN   = 4'h6,
      PMW_WAKE_OSC  = 4'h8,
      PMW_WAKE_DOM  = 4'h9,
      PMW_WAKE_INIT = 4'ha
   } pmw_state_e;

   typedef struct packed {
      logic primary_fast_oscillator;
      logic secondary_oscillator;
      logic baud_rate_oscillator;
      logic nano_ring_oscillator;
      logic rtc_crystal_oscillator;
      logic rf_crystal_oscillator;
   } pmw_osc_s;

   typedef struct packed {
      logic       hs_serial;
      logic       timer;
      logic       watchdog;
      logic       wakeup_timer;
      logic [3:0] comparator;
      logic       rtc;
      logic       gpio;
      logic       coprocessor_core;
      logic       lowpower_serial_port_a;
      logic       lowpower_serial_port_b;
      logic       lowpower_timer_b;
      logic       lowpower_timer_c;
      logic       lowpower_watchdog;
   } pmw_wake_s;

   typedef struct packed {
      logic       main_core_clk;
      logic       main_core_retain;
      logic       main_core_pwr;
      logic       coproc_clk;
      logic       coproc_retain;
      logic       coproc_pwr;
      logic       periph_pwr;
      logic       periph_clk;
      logic       periph_retain;
      logic       lp_periph_clk;
      logic       coproc_periph_clk;
      logic       gpio_hold;
      logic       rtc_run;
      logic       dma_en;
      logic       dma_flash;
      logic       flash_en;
      logic       coproc_icache;
      logic       mon_en;
      logic [3:0] ram_pwr;
      logic [3:0] ram_retain;
      logic [3:0] ram_coproc;
   } pmw_dom_s;

endpackage : pmw_pkg

// File: verilog/pmw_sync.sv
/*
 Two-flop synchroniser for a vector of asynchronous inputs.
 Assumes each bit is an independent level.
*/
`timescale 1ns/1ps
module pmw_sync #(
   parameter int WIDTH = 25
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : pmw_sync

// File: verilog/pmw_wakegate.sv
/*
 Selects which synchronised wake sources may end each low-power state.
 Assumes all inputs are already in the clock domain.
*/
`timescale 1ns/1ps
module pmw_wakegate
   import pmw_pkg::*;
(
   // State
   input  wire pmw_state_e state,
   // Sources
   input  wire pmw_wake_s  src,
   input  wire logic [7:0] periph_irq,
   input  wire logic [7:0] wake_en,
   input  wire logic       pin_low,
   // Result
   output logic            wake
);
   wire any_cmp  = |src.comparator;
   wire lp_set   = src.lowpower_serial_port_a | src.lowpower_serial_port_b
                 | src.lowpower_timer_b | src.lowpower_timer_c
                 | src.lowpower_watchdog;
   wire slow_set = src.rtc | src.wakeup_timer | src.gpio;
   wire w_sleep  = (|(periph_irq & wake_en)) | pin_low;
   wire w_lp     = src.hs_serial | src.timer | src.watchdog | lp_set | any_cmp
                 | slow_set | src.coprocessor_core | pin_low;
   wire w_micro  = any_cmp | lp_set | slow_set | pin_low;
   wire w_stby   = slow_set | src.comparator[0] | pin_low;

   assign wake = (state == PMW_SLEEP)   ? w_sleep :
                 (state == PMW_LOWPWR)  ? w_lp :
                 (state == PMW_MICRO)   ? w_micro :
                 (state == PMW_STANDBY) ? w_stby :
                 (state == PMW_BACKUP)  ? w_stby :
                 (state == PMW_PWRDOWN) ? pin_low : 1'b0;
endmodule : pmw_wakegate

// File: verilog/pmw_ctrl.sv
/*
 Power-mode and wake controller: seven operating states, per-state core,
 RAM, peripheral and oscillator control, wake gating and wake sequencing,
 with an Avalon-MM register slave.
 Assumes a 10 MHz clock, word addressing, and wake sources that may come
 from other clock domains.
*/
`timescale 1ns/1ps
`include "pmw_consts.svh"

module pmw_ctrl
   import pmw_pkg::*;
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Pins and wake sources
   input  wire logic        external_reset_pin_n,
   input  wire pmw_wake_s   wake_src,
   input  wire logic [7:0]  periph_irq,
   // Peripheral activity, same clock
   input  wire logic [7:0]  periph_busy,
   // Controls
   output pmw_osc_s         osc_en,
   output logic [1:0]       nano_freq_sel,
   output pmw_dom_s         dom,
   output logic [7:0]       periph_clk_en,
   output pmw_state_e       state
);
   // Register state
   pmw_state_e  state_reg, state_next;
   pmw_state_e  from_reg, from_next;
   logic [7:0]  cnt_reg, cnt_next;
   logic        ack_reg;
   logic [31:0] readdata_reg;
   logic        pfo_off_reg;
   logic        bro_off_reg;
   logic        icache_reg;
   logic [1:0]  nro_reg;
   logic [3:0]  retain_reg;
   logic [7:0]  wake_en_reg;
   logic        woke_reg, woke_next;
   pmw_osc_s    osc_reg, osc_next;
   pmw_dom_s    dom_reg, dom_next;
   logic [7:0]  pclk_reg, pclk_next;

   // Synchronised inputs
   logic [24:0] sync_q;
   pmw_wake_s   src_s;
   logic [7:0]  irq_s;
   logic        pin_low;
   logic        wake;

   pmw_sync #(
      .WIDTH (25)
   ) u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in ({wake_src, periph_irq, ~external_reset_pin_n}),
      .sync_out (sync_q)
   );

   assign src_s   = sync_q[24:9];
   assign irq_s   = sync_q[8:1];
   assign pin_low = sync_q[0];

   pmw_wakegate u_wakegate (
      .state      (state_reg),
      .src        (src_s),
      .periph_irq (irq_s),
      .wake_en    (wake_en_reg),
      .pin_low    (pin_low),
      .wake       (wake)
   );

   // Oscillator enables per state
   function automatic pmw_osc_s osc_of(input pmw_state_e s,
                                       input logic pfo_off,
                                       input logic bro_off);
      pmw_osc_s o;
      o = '0;
      unique case (s)
         PMW_LOWPWR: begin
            o = '1;
            o.primary_fast_oscillator = ~pfo_off;
         end
         PMW_MICRO: begin
            o.baud_rate_oscillator   = ~bro_off;
            o.rtc_crystal_oscillator = 1'b1;
            o.nano_ring_oscillator   = 1'b1;
         end
         PMW_STANDBY: begin
            o.rtc_crystal_oscillator = 1'b1;
            o.nano_ring_oscillator   = 1'b1;
         end
         PMW_BACKUP: begin
            o.rtc_crystal_oscillator = 1'b1;
         end
         PMW_PWRDOWN: begin
            o = '0;
         end
         default: begin
            o = '1;
         end
      endcase
      return o;
   endfunction : osc_of

   // Domain controls per state
   function automatic pmw_dom_s dom_of(input pmw_state_e s,
                                       input logic icache,
                                       input logic [3:0] retain);
      pmw_dom_s d;
      d = '0;
      d.mon_en  = 1'b1;
      d.rtc_run = (s != PMW_PWRDOWN);
      unique case (s)
         PMW_ACTIVE, PMW_SLEEP: begin
            d.main_core_pwr = 1'b1;
            d.coproc_pwr    = 1'b1;
            d.periph_pwr    = 1'b1;
            d.periph_clk    = 1'b1;
            d.dma_en        = 1'b1;
            d.dma_flash     = 1'b1;
            d.flash_en      = 1'b1;
            d.ram_pwr       = 4'hf;
            if (s == PMW_ACTIVE) begin
               d.main_core_clk = 1'b1;
               d.coproc_clk    = 1'b1;
               d.coproc_icache = icache;
               d.ram_coproc    = `PMW_COPROC_BANKS;
            end
         end
         PMW_LOWPWR: begin
            d.main_core_pwr     = 1'b1;
            d.main_core_retain  = 1'b1;
            d.coproc_clk        = 1'b1;
            d.coproc_pwr        = 1'b1;
            d.periph_pwr        = 1'b1;
            d.coproc_periph_clk = 1'b1;
            d.coproc_icache     = icache;
            d.ram_pwr           = `PMW_COPROC_BANKS;
            d.ram_retain        = `PMW_LP_RET_BANKS;
            d.ram_coproc        = `PMW_COPROC_BANKS;
            d.dma_en            = 1'b1;
            d.dma_flash         = 1'b1;
            d.flash_en          = 1'b1;
         end
         PMW_MICRO, PMW_STANDBY: begin
            d.main_core_pwr    = 1'b1;
            d.main_core_retain = 1'b1;
            d.coproc_pwr       = 1'b1;
            d.coproc_retain    = 1'b1;
            d.periph_pwr       = 1'b1;
            d.periph_retain    = 1'b1;
            d.lp_periph_clk    = (s == PMW_MICRO);
            d.gpio_hold        = 1'b1;
            d.ram_retain       = 4'hf;
         end
         PMW_BACKUP: begin
            d.gpio_hold  = 1'b1;
            d.ram_retain = retain;
         end
         PMW_PWRDOWN: begin
            d.rtc_run = 1'b0;
         end
         default: begin
            d.main_core_pwr = 1'b1;
            d.coproc_pwr    = 1'b1;
            d.periph_pwr    = 1'b1;
            d.periph_clk    = 1'b1;
            d.gpio_hold     = 1'b1;
            d.flash_en      = 1'b1;
            d.ram_pwr       = 4'hf;
         end
      endcase
      return d;
   endfunction : dom_of

   // Bus decode
   wire       req      = read | write;
   wire       wr_fire  = write & ack_reg;
   wire       wr_ctrl  = wr_fire & (address == `PMW_OFS_CTRL);
   wire       wr_stat  = wr_fire & (address == `PMW_OFS_STATUS);
   wire       wr_wken  = wr_fire & (address == `PMW_OFS_WAKE_EN);
   wire [2:0] req_mode = writedata[`PMW_CTRL_MODE_LSB +: 3];
   wire       go       = wr_ctrl & writedata[`PMW_CTRL_GO_BIT]
                       & (req_mode != 3'h0) & (req_mode != 3'h7);
   wire [1:0] nro_w    = writedata[`PMW_CTRL_NRO_LSB +: 2];
   wire       pfo_eff  = wr_ctrl ? writedata[`PMW_CTRL_PFO_BIT] : pfo_off_reg;
   wire       bro_eff  = wr_ctrl ? writedata[`PMW_CTRL_BRO_BIT] : bro_off_reg;
   wire       ic_eff   = wr_ctrl ? writedata[`PMW_CTRL_ICACHE_BIT] : icache_reg;
   wire [3:0] ret_eff  = wr_ctrl ? writedata[`PMW_CTRL_RET_LSB +: 4] : retain_reg;
   wire [1:0] nro_eff  = (wr_ctrl && (nro_w != `PMW_NRO_ILLEGAL)) ? nro_w : nro_reg;
   wire       woke_clr = wr_stat & writedata[`PMW_STAT_WOKE_BIT];
   wire       busy     = state_reg[3];

   wire [31:0] rd_ctrl = {16'h0, retain_reg, 2'h0, nro_reg, 1'b0, icache_reg,
                          bro_off_reg, pfo_off_reg, 4'h0};
   wire [31:0] rd_stat = {23'h0, woke_reg, 3'h0, busy, state_reg};
   wire [31:0] rd_mux  =
      (address == `PMW_OFS_CTRL)    ? rd_ctrl :
      (address == `PMW_OFS_STATUS)  ? rd_stat :
      (address == `PMW_OFS_WAKE_EN) ? {24'h0, wake_en_reg} :
      (address == `PMW_OFS_DOMAIN)  ? {2'h0, dom_reg} :
      (address == `PMW_OFS_OSC)     ? {26'h0, osc_reg} : 32'h0;
   assign waitrequest = req & ~ack_reg;

   // Sequencer
   wire cnt_done = (cnt_reg == 8'h0);
   always_comb begin
      state_next = state_reg;
      from_next  = from_reg;
      cnt_next   = cnt_done ? 8'h0 : cnt_reg - 8'h1;
      woke_next  = woke_reg & ~woke_clr;
      unique case (state_reg)
         PMW_ACTIVE: begin
            if (go) begin
               state_next = pmw_state_e'({1'b0, req_mode});
            end
         end
         PMW_SLEEP: begin
            if (wake) begin
               state_next = PMW_ACTIVE;
               woke_next  = 1'b1;
            end
         end
         PMW_LOWPWR, PMW_MICRO, PMW_STANDBY, PMW_BACKUP, PMW_PWRDOWN: begin
            if (wake) begin
               state_next = PMW_WAKE_OSC;
               from_next  = state_reg;
               cnt_next   = 8'(`PMW_OSC_SETTLE_CYC);
               woke_next  = 1'b1;
            end
         end
         PMW_WAKE_OSC: begin
            if (cnt_done) begin
               state_next = PMW_WAKE_DOM;
               cnt_next   = 8'(`PMW_DOM_SETTLE_CYC);
            end
         end
         PMW_WAKE_DOM: begin
            if (cnt_done) begin
               if ((from_reg == PMW_BACKUP) || (from_reg == PMW_PWRDOWN)) begin
                  state_next = PMW_WAKE_INIT;
                  cnt_next   = 8'(`PMW_SYS_INIT_CYC);
               end else begin
                  state_next = PMW_ACTIVE;
               end
            end
         end
         PMW_WAKE_INIT: begin
            if (cnt_done) begin
               state_next = PMW_ACTIVE;
            end
         end
         default: begin
            state_next = PMW_ACTIVE;
         end
      endcase
   end

   // Output controls
   assign osc_next = osc_of(state_next, pfo_eff, bro_eff);
   assign dom_next = (state_next == PMW_WAKE_OSC)
                   ? dom_of(from_next, ic_eff, ret_eff)
                   : dom_of(state_next, ic_eff, ret_eff);
   assign pclk_next = (state_next == PMW_SLEEP) ? 8'hff :
                      ((state_next == PMW_ACTIVE) ||
                       (state_next == PMW_LOWPWR)) ? periph_busy : 8'h0;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PMW_ACTIVE;
         from_reg  <= PMW_ACTIVE;
         cnt_reg   <= 8'h0;
         woke_reg  <= 1'b0;
         osc_reg   <= '1;
         dom_reg   <= '0;
         pclk_reg  <= 8'h0;
      end else begin
         state_reg <= state_next;
         from_reg  <= from_next;
         cnt_reg   <= cnt_next;
         woke_reg  <= woke_next;
         osc_reg   <= osc_next;
         dom_reg   <= dom_next;
         pclk_reg  <= pclk_next;
      end
   end

   // Bus handshake and read data
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg      <= 1'b0;
         readdata_reg <= 32'h0;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (read & ~ack_reg) begin
            readdata_reg <= rd_mux;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pfo_off_reg <= 1'b0;
         bro_off_reg <= 1'b0;
         icache_reg  <= 1'b0;
         nro_reg     <= `PMW_NRO_RST;
         retain_reg  <= `PMW_RET_RST;
         wake_en_reg <= `PMW_WAKE_EN_RST;
      end else begin
         pfo_off_reg <= pfo_eff;
         bro_off_reg <= bro_eff;
         icache_reg  <= ic_eff;
         retain_reg  <= ret_eff;
         nro_reg     <= nro_eff;
         if (wr_wken) begin
            wake_en_reg <= writedata[7:0];
         end
      end
   end

   assign readdata      = readdata_reg;
   assign osc_en        = osc_reg;
   assign nano_freq_sel = nro_reg;
   assign dom           = dom_reg;
   assign periph_clk_en = pclk_reg;
   assign state         = state_reg;
endmodule : pmw_ctrl

// File: testbench/pmw_ctrl_properties.sv
/* Assertions on the power-mode controller ports.
   Assumes binding onto pmw_ctrl. */
`timescale 1ns/1ps
module pmw_ctrl_properties
   import pmw_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // Bus
   input wire logic [3:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // Wake
   input wire logic        external_reset_pin_n,
   input wire pmw_wake_s   wake_src,
   input wire logic [7:0]  periph_irq,
   input wire logic [7:0]  periph_busy,
   // Controls
   input wire pmw_osc_s    osc_en,
   input wire logic [1:0]  nano_freq_sel,
   input wire pmw_dom_s    dom,
   input wire logic [7:0]  periph_clk_en,
   input wire pmw_state_e  state
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   nano_legal_a: assert property (nano_freq_sel != 2'h3)
      else $error("nano select illegal");
   clk_gating_a: assert property ($past(rst_n) && state == PMW_ACTIVE
      && $past(state) == PMW_ACTIVE |-> periph_clk_en == $past(periph_busy))
      else $error("clock gating wrong");
   sleep_domains_a: assert property (state == PMW_SLEEP |-> !dom.main_core_clk
      && !dom.coproc_clk && dom.periph_clk && dom.dma_en) else $error("sleep wrong");
   lp_retain_a: assert property (state == PMW_LOWPWR |-> dom.main_core_retain
      && dom.ram_retain[1:0] == 2'h3 && dom.coproc_clk && dom.ram_coproc == 4'hc)
      else $error("low-power domains wrong");
   lp_osc_a: assert property (state == PMW_LOWPWR |-> osc_en[4:0] == 5'h1f)
      else $error("low-power osc wrong");
   lp_dma_a: assert property (state == PMW_LOWPWR |-> dom.dma_flash)
      else $error("dma flash off");
   micro_hold_a: assert property (state == PMW_MICRO |-> dom.gpio_hold
      && dom.main_core_retain && osc_en[5:4] == 2'h0 && osc_en[2:0] == 3'h6)
      else $error("micro wrong");
   standby_osc_a: assert property (state == PMW_STANDBY |-> osc_en == 6'h06
      && dom.gpio_hold && dom.rtc_run) else $error("standby wrong");
   backup_off_a: assert property (state == PMW_BACKUP |-> osc_en == 6'h02
      && !dom.main_core_pwr && !dom.periph_pwr && dom.rtc_run) else $error("backup wrong");
   pdown_off_a: assert property (state == PMW_PWRDOWN |-> osc_en == 6'h00
      && dom.ram_pwr == 4'h0) else $error("power-down wrong");
   wake_order_a: assert property ($rose(state == PMW_WAKE_OSC) |-> osc_en == 6'h3f
      ##21 state == PMW_WAKE_DOM) else $error("wake order wrong");
   cover property (state == PMW_WAKE_INIT);
   cover property (state == PMW_MICRO);
   cover property (state == PMW_BACKUP);
endmodule : pmw_ctrl_properties

bind pmw_ctrl pmw_ctrl_properties u_props (.clock(clock), .rst_n(rst_n),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .periph_irq(periph_irq),
   .external_reset_pin_n(external_reset_pin_n), .wake_src(wake_src),
   .periph_busy(periph_busy), .osc_en(osc_en), .nano_freq_sel(nano_freq_sel),
   .dom(dom), .periph_clk_en(periph_clk_en), .state(state));

// File: testbench/pmw_wake_model.sv
/* Wake source peripherals: one selected line after a lag.
   Assumes the bench drops on between requests. */
`timescale 1ns/1ps
module pmw_wake_model
   import pmw_pkg::*;
(
   // Clock
   input wire logic       clock,
   // Request
   input wire logic       on,
   input wire logic [4:0] sel,
   input wire logic [3:0] lag,
   // Lines
   output pmw_wake_s      src,
   output logic [7:0]     irq,
   output logic           pin_n
);
   logic [3:0]  cnt = 4'h0;
   logic [24:0] lines = 25'h0;
   always_ff @(posedge clock) begin
      if (!on) begin
         cnt <= lag;
         lines <= 25'h0;
      end else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      else lines <= 25'h1 << sel;
   end
   assign src = lines[15:0];
   assign irq = lines[23:16];
   assign pin_n = ~lines[24];
endmodule : pmw_wake_model

// File: testbench/tb.sv
/* Self-checking bench of the power-mode controller.
   Assumes pmw_ctrl, the wake model and the checker. */
`timescale 1ns/1ps
`include "pmw_consts.svh"
module tb
   import pmw_pkg::*;
;
   logic clock = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, on = 1'b0, saw;
   logic [3:0] address = 4'h0, lag = 4'h0, r;
   logic [4:0] sel = 5'h0;
   logic [7:0] periph_busy = 8'h0, e, irq;
   logic [31:0] writedata = 32'h0, q, readdata;
   logic waitrequest, pin_n, p, b;
   logic [1:0] nano_freq_sel;
   logic [7:0] periph_clk_en;
   pmw_wake_s wake_src;
   pmw_osc_s osc_en;
   pmw_dom_s dom;
   pmw_state_e state;
   int n_errors = 0, n_tests = 0, m, n, nx;
   pmw_ctrl uut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .external_reset_pin_n(pin_n), .wake_src(wake_src),
      .periph_irq(irq), .periph_busy(periph_busy), .osc_en(osc_en),
      .nano_freq_sel(nano_freq_sel), .dom(dom), .periph_clk_en(periph_clk_en),
      .state(state));
   pmw_wake_model u_far (.clock(clock), .on(on), .sel(sel), .lag(lag),
      .src(wake_src), .irq(irq), .pin_n(pin_n));
   always #50 clock = ~clock;
   always @(posedge clock) periph_busy <= 8'($urandom);
   task finish_test;
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      do begin
         @(posedge clock);
         k = k + 1;
      end while (waitrequest !== 1'b0 && k < 50);
      chk(k < 50, 1);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus
   function automatic bit ok(int md, int i, logic [7:0] en);
      logic [15:0] mk;
      mk = md == 2 ? 16'hffff : md == 3 ? 16'h1fdf : md inside {4, 5} ? 16'h11c0 : 16'h0;
      if (i == 24) return 1'b1;
      if (md == 1) return i > 15 && en[i-16];
      return i < 16 && mk[i];
   endfunction : ok
   function automatic logic [5:0] xosc(int md, logic po, logic bo);
      case (md)
         2: return {~po, 5'h1f};
         3: return {2'h0, ~bo, 3'h6};
         4: return 6'h06;
         5: return 6'h02;
         default: return 6'h00;
      endcase
   endfunction : xosc
   task pick(input bit want);
      int i;
      do i = $urandom_range(24, 0); while (ok(m, i, e) != want);
      @(posedge clock);
      sel <= i[4:0];
      lag <= 4'($urandom);
      on <= 1'b1;
   endtask : pick
   initial begin
      repeat (30000) @(posedge clock);
      $display("Error %0t: timeout", $time);
      n_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(29899));
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      bus(0, `PMW_OFS_CTRL, 32'h0);
      chk(q, 32'h0000f000);
      bus(0, `PMW_OFS_OSC, 32'h0);
      chk(q, 32'h3f);
      bus(0, 4'hf, 32'h0);
      chk(q, 32'h0);
      for (int f = 0; f < 4; f++) begin
         bus(1, `PMW_OFS_CTRL, {16'h0, 4'hf, 2'h0, 2'(f), 8'h0});
         repeat (2) @(negedge clock);
         if (f < 3) nx = f;
         chk(nano_freq_sel, nx);
      end
      bus(1, `PMW_OFS_CTRL, 32'h0000f00f);
      @(negedge clock);
      chk(state, 0);
      for (int it = 0; it < 18; it++) begin
         m = it % 6 + 1;
         {p, b, r} = 6'($urandom);
         e = 8'($urandom) & 8'h7f | 8'h01;
         bus(1, `PMW_OFS_WAKE_EN, {24'h0, e});
         bus(1, `PMW_OFS_CTRL, {16'h0, r, 6'h0, b, p, 1'b1, 3'(m)});
         @(negedge clock);
         chk(state, m);
         if (m > 1) chk(osc_en, xosc(m, p, b));
         if (m == 5) chk(dom.ram_retain, r);
         bus(1, `PMW_OFS_CTRL, {16'h0, r, 6'h0, b, p, 1'b1, 3'(m % 6 + 1)});
         bus(0, `PMW_OFS_STATUS, 32'h0);
         chk(q, 32'(m));
         pick(0);
         repeat (24) @(posedge clock);
         chk(state, m);
         on <= 1'b0;
         repeat (4) @(posedge clock);
         pick(1);
         saw = 1'b0;
         n = 0;
         while (state !== PMW_ACTIVE && n < 300) begin
            @(posedge clock);
            n++;
            if (state === PMW_WAKE_INIT) saw = 1'b1;
         end
         chk(state, 0);
         chk(saw, m > 4);
         bus(0, `PMW_OFS_STATUS, 32'h0);
         chk(q, 32'h100);
         bus(1, `PMW_OFS_STATUS, 32'h100);
         on <= 1'b0;
         repeat (4) @(posedge clock);
      end
      finish_test();
   end
endmodule : tb
